// file: led_port_pkg.sv
// constants and types shared by the serial load port and its buffer
package led_port_pkg;
    // clocking and refresh timing
    localparam int unsigned CLK_HZ      = 10_000_000;   // ref_clk rate
    localparam int unsigned REFRESH_HZ  = 1000;         // nominal, inside 700..1900 Hz
    localparam int unsigned BANK_COUNT  = 5;
    localparam int unsigned BANK_CYCLES = CLK_HZ / (REFRESH_HZ * BANK_COUNT);
    localparam int unsigned BANK_CNT_W  = 11;
    localparam logic [BANK_CNT_W-1:0] BANK_LAST = BANK_CNT_W'(BANK_CYCLES - 1);

    // register widths and frame lengths in bits
    localparam int unsigned CFG_W  = 8;
    localparam int unsigned DISP_W = 24;
    localparam int unsigned CNT_W  = 6;
    localparam logic [CNT_W-1:0] LEN_CFG       = 6'h08;   // single device, 1 byte
    localparam logic [CNT_W-1:0] LEN_DISP      = 6'h18;   // single device, 3 bytes
    localparam logic [CNT_W-1:0] LEN_CASC_CFG  = 6'h20;   // two devices, 4 bytes
    localparam logic [CNT_W-1:0] LEN_CASC_DISP = 6'h30;   // two devices, 6 bytes
    localparam logic [CNT_W-1:0] CNT_MAX       = 6'h3f;

    // reset values: configuration bit 0 low keeps the banks dark
    localparam logic [CFG_W-1:0]  CFG_RESET  = 8'h00;
    localparam logic [DISP_W-1:0] DISP_RESET = 24'h000000;
    localparam int unsigned CFG_ENABLE_BIT   = 0;

    // one buffered load: target flag on top, payload below
    localparam int unsigned LOAD_W     = DISP_W + 1;
    localparam int unsigned LOAD_SEL_BIT = DISP_W;

    // frame states, one-hot
    typedef enum logic [2:0] {
        PORT_IDLE  = 3'b001,
        PORT_FRAME = 3'b010,
        PORT_HOLD  = 3'b100
    } port_state_t;
endpackage : led_port_pkg

// file: two_entry_buffer.sv
// two-entry valid/ready buffer carrying finished loads toward the registers
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer
    import led_port_pkg::*;
#(
    parameter int unsigned WIDTH = LOAD_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] store [2];
    logic [WIDTH-1:0] next_store [2];
    logic             wrPtr;
    logic             next_wrPtr;
    logic             rdPtr;
    logic             next_rdPtr;
    logic [1:0]       fill;
    logic [1:0]       next_fill;
    logic             doPush;
    logic             doPop;

    // full and empty come straight from the fill count
    assign inReady  = (fill != 2'h2);
    assign outValid = (fill != 2'h0);
    assign outData  = store[rdPtr];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // pointer and fill bookkeeping
    always_comb begin
        next_store = store;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_fill  = fill;
        if (doPush) begin
            next_store[wrPtr] = inData;
            next_wrPtr        = ~wrPtr;
        end
        if (doPop) begin
            next_rdPtr = ~rdPtr;
        end
        if (doPush && !doPop) begin
            next_fill = fill + 2'h1;
        end else if (doPop && !doPush) begin
            next_fill = fill - 2'h1;
        end
    end

    // storage needs no reset, only the bookkeeping does
    always_ff @(posedge ref_clk) begin
        store <= next_store;
        if (!rst_n) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            fill  <= 2'h0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            fill  <= next_fill;
        end
    end
endmodule : two_entry_buffer
`default_nettype wire

// file: led_serial_port.sv
// serial load port of the led driver with its bank refresh scan
`timescale 1ns/1ns
`default_nettype none
module led_serial_port
    import led_port_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              serialClk,
    input  wire logic              serialIn,
    input  wire logic              loadEnable_n,
    input  wire logic              cascaded,
    output logic                   serialOut,
    output logic      [CFG_W-1:0]  configReg,
    output logic      [DISP_W-1:0] displayReg,
    output logic      [4:0]        bankSelect
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]  clkSync;
    logic [1:0]  dataSync;
    logic [1:0]  enSync;
    logic [1:0]  cascSync;
    logic        clkLast;
    logic        enLast;
    logic        clkRise;
    logic        clkFall;
    logic        enRise;
    logic        enLow;

    // two flops per pin; only the second stage is read beyond here
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clkSync  <= 2'h0;
            dataSync <= 2'h0;
            enSync   <= 2'h3;
            cascSync <= 2'h0;
            clkLast  <= 1'b0;
            enLast   <= 1'b1;
        end else begin
            clkSync  <= {clkSync[0], serialClk};
            dataSync <= {dataSync[0], serialIn};
            enSync   <= {enSync[0], loadEnable_n};
            cascSync <= {cascSync[0], cascaded};
            clkLast  <= clkSync[1];
            enLast   <= enSync[1];
        end
    end

    assign clkRise = clkSync[1] && !clkLast;
    assign clkFall = !clkSync[1] && clkLast;
    assign enRise  = enSync[1] && !enLast;
    assign enLow   = !enSync[1];

    ////////////////////////////////////////////////////////////////////////////
    // frame length decoding
    ////////////////////////////////////////////////////////////////////////////
    // returns 2'b01 for config, 2'b10 for display, 2'b00 for no match
    function automatic logic [1:0] frame_target(input logic [CNT_W-1:0] bits,
                                                input logic            chain);
        logic [1:0] result;
        result = 2'b00;
        if (chain) begin
            if (bits == LEN_CASC_CFG) begin
                result = 2'b01;
            end else if (bits == LEN_CASC_DISP) begin
                result = 2'b10;
            end
        end else begin
            if (bits == LEN_CFG) begin
                result = 2'b01;
            end else if (bits == LEN_DISP) begin
                result = 2'b10;
            end
        end
        return result;
    endfunction : frame_target

    ////////////////////////////////////////////////////////////////////////////
    // shift frame state machine
    ////////////////////////////////////////////////////////////////////////////
    port_state_t         state;
    port_state_t         next_state;
    logic [DISP_W-1:0]   shifter;
    logic [DISP_W-1:0]   next_shifter;
    logic [CNT_W-1:0]    bitCount;
    logic [CNT_W-1:0]    next_bitCount;
    logic                next_serialOut;
    logic [LOAD_W-1:0]   pendWord;
    logic [LOAD_W-1:0]   next_pendWord;
    logic [1:0]          target;
    logic                bufInReady;

    assign target = frame_target(bitCount, cascSync[1]);

    // shifting, counting and capture of the finished frame
    always_comb begin
        next_state     = state;
        next_shifter   = shifter;
        next_bitCount  = bitCount;
        next_serialOut = serialOut;
        next_pendWord  = pendWord;
        case (state)
            PORT_IDLE: begin
                next_bitCount  = '0;
                next_serialOut = 1'b0;
                if (enLow) begin
                    next_state = PORT_FRAME;
                end
            end
            PORT_FRAME: begin
                if (enRise) begin
                    next_serialOut = 1'b0;
                    if (target == 2'b10) begin
                        next_pendWord = {1'b1, shifter};
                        next_state    = PORT_HOLD;
                    end else if (target == 2'b01) begin
                        next_pendWord = {1'b0, {(DISP_W-CFG_W){1'b0}},
                                         shifter[CFG_W-1:0]};
                        next_state    = PORT_HOLD;
                    end else begin
                        next_state = PORT_IDLE;
                    end
                end else if (clkRise) begin
                    // msb arrives first and moves up toward the top stage
                    next_shifter = {shifter[DISP_W-2:0], dataSync[1]};
                    if (bitCount != CNT_MAX) begin
                        next_bitCount = bitCount + 6'h01;
                    end
                end else if (clkFall) begin
                    next_serialOut = shifter[DISP_W-1];
                end
            end
            PORT_HOLD: begin
                // waits for buffer room; a stalled drain backs up to here
                next_serialOut = 1'b0;
                next_bitCount  = '0;
                if (bufInReady) begin
                    next_state = PORT_IDLE;
                end
            end
            default: begin
                next_state = PORT_IDLE;
            end
        endcase
    end

    // frame registers; reset forces the port back to idle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state     <= PORT_IDLE;
            shifter   <= DISP_RESET;
            bitCount  <= '0;
            serialOut <= 1'b0;
            pendWord  <= '0;
        end else begin
            state     <= next_state;
            shifter   <= next_shifter;
            bitCount  <= next_bitCount;
            serialOut <= next_serialOut;
            pendWord  <= next_pendWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // load buffer between the port and the visible registers
    ////////////////////////////////////////////////////////////////////////////
    logic                bufOutValid;
    logic                bufOutReady;
    logic [LOAD_W-1:0]   bufOutData;

    two_entry_buffer #(
        .WIDTH (LOAD_W)
    ) loadBuffer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .inValid  (state == PORT_HOLD),
        .inReady  (bufInReady),
        .inData   (pendWord),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOutData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // visible registers and bank refresh scan
    ////////////////////////////////////////////////////////////////////////////
    logic [BANK_CNT_W-1:0] bankTimer;
    logic [BANK_CNT_W-1:0] next_bankTimer;
    logic [4:0]            bankRing;
    logic [4:0]            next_bankRing;
    logic [CFG_W-1:0]      next_configReg;
    logic [DISP_W-1:0]     next_displayReg;
    logic [4:0]            next_bankSelect;
    logic                  bankEnd;

    // loads land only at a bank boundary, so a bank never changes mid-slot
    assign bankEnd     = (bankTimer == BANK_LAST);
    assign bufOutReady = bankEnd;

    always_comb begin
        next_bankTimer  = bankEnd ? '0 : bankTimer + 11'h001;
        next_bankRing   = bankEnd ? {bankRing[3:0], bankRing[4]} : bankRing;
        next_configReg  = configReg;
        next_displayReg = displayReg;
        if (bufOutValid && bufOutReady) begin
            // either register may be loaded at any bank boundary
            if (bufOutData[LOAD_SEL_BIT]) begin
                next_displayReg = bufOutData[DISP_W-1:0];
            end else begin
                next_configReg = bufOutData[CFG_W-1:0];
            end
        end
        // config bit 0 low blanks all banks
        next_bankSelect = next_configReg[CFG_ENABLE_BIT] ? next_bankRing : 5'h00;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bankTimer  <= '0;
            bankRing   <= 5'h01;
            configReg  <= CFG_RESET;
            displayReg <= DISP_RESET;
            bankSelect <= 5'h00;
        end else begin
            bankTimer  <= next_bankTimer;
            bankRing   <= next_bankRing;
            configReg  <= next_configReg;
            displayReg <= next_displayReg;
            bankSelect <= next_bankSelect;
        end
    end
endmodule : led_serial_port
`default_nettype wire

// file: led_serial_port_sva.sv
// assertion checker for the led serial load port
`timescale 1ns/1ns
`default_nettype none
module led_serial_port_sva
    import led_port_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              serialClk,
    input wire logic              serialIn,
    input wire logic              loadEnable_n,
    input wire logic              cascaded,
    input wire logic              serialOut,
    input wire logic [CFG_W-1:0]  configReg,
    input wire logic [DISP_W-1:0] displayReg,
    input wire logic [4:0]        bankSelect
);
    localparam int LOAD_MAX = 6100;   // three queued loads, one per bank slot
    localparam int SLOT_MIN = 1052;   // 1900 Hz over five banks
    localparam int SLOT_MAX = 2857;   // 700 Hz over five banks
    int slotCnt;
    int sinceRise;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_idleLong;
        loadEnable_n [*8];
    endsequence
    sequence s_frameEnd;
        $rose(loadEnable_n);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // slot length and time since last frame end; dark banks restart the count
    always_ff @(posedge ref_clk) begin
        slotCnt   <= ($changed(bankSelect) || !configReg[CFG_ENABLE_BIT] || !rst_n) ? 0
                     : slotCnt + 1;
        sinceRise <= !rst_n ? LOAD_MAX + 1 : $rose(loadEnable_n) ? 0
                     : (sinceRise > LOAD_MAX) ? sinceRise : sinceRise + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    reset_clear_a: assert property ($rose(rst_n) |-> configReg == CFG_RESET
        && displayReg == DISP_RESET && !serialOut && bankSelect == 5'h00)
        else $error("outputs not cleared by reset");
    idle_low_a: assert property (s_idleLong |-> !serialOut)
        else $error("serial output high while disabled");
    out_fall_a: assert property ($changed(serialOut) |-> !serialClk)
        else $error("serial output moved with clock high");
    bank_dark_a: assert property (!configReg[CFG_ENABLE_BIT] |-> bankSelect == 5'h00)
        else $error("bank driven while display off");
    bank_onehot_a: assert property ($onehot0(bankSelect))
        else $error("more than one bank driven");
    bank_stall_a: assert property (configReg[CFG_ENABLE_BIT] |-> slotCnt <= SLOT_MAX)
        else $error("bank scan stalled");
    bank_rate_a: assert property ($changed(bankSelect) && $past(bankSelect) != 5'h00
        && bankSelect != 5'h00 |-> slotCnt >= SLOT_MIN - 1 && slotCnt <= SLOT_MAX)
        else $error("bank slot length out of range");
    load_late_a: assert property ($changed(configReg) || $changed(displayReg)
        |-> sinceRise <= LOAD_MAX)
        else $error("register changed without a frame end");
    disp_blank_a: assert property ($changed(displayReg) && configReg[0]
        && $past(configReg[0]) |-> $changed(bankSelect))
        else $error("display changed outside a bank boundary");
    frame_end_c: cover property (s_frameEnd ##1 s_idleLong);
endmodule : led_serial_port_sva
bind led_serial_port led_serial_port_sva chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .serialClk(serialClk), .serialIn(serialIn), .loadEnable_n(loadEnable_n),
    .cascaded(cascaded), .serialOut(serialOut), .configReg(configReg),
    .displayReg(displayReg), .bankSelect(bankSelect));
`default_nettype wire

// file: led_host_model.sv
// host side model: sends frames and captures the chained serial output
`timescale 1ns/1ns
`default_nettype none
module led_host_model (
    input  wire logic ref_clk,
    input  wire logic serialOut,
    output var logic  serialClk,
    output var logic  serialIn,
    output var logic  loadEnable_n
);
    logic busy;
    logic echo [$];
    initial begin
        serialClk    = 1'b0;
        serialIn     = 1'b0;
        loadEnable_n = 1'b1;
        busy         = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // released data line toggles so a stale bit never looks valid
    always @(posedge ref_clk) begin
        if (!busy) serialIn <= ~serialIn;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one frame; half is the serial half period in ref_clk cycles
    task automatic sendFrame(input logic [47:0] bits, input int len, input int half);
        busy = 1'b1;
        echo.delete();
        @(posedge ref_clk);
        loadEnable_n <= 1'b0; // clock is low here
        for (int i = len - 1; i >= 0; i--) begin
            serialIn <= bits[i]; // msb first, changed at the fall
            repeat (half) @(posedge ref_clk);
            serialClk <= 1'b1;
            echo.push_back(serialOut); // downstream capture on rise
            repeat (half) @(posedge ref_clk);
            serialClk <= 1'b0;
        end
        repeat (half) @(posedge ref_clk);
        loadEnable_n <= 1'b1; // clock low again
        repeat (4) @(posedge ref_clk);
        busy = 1'b0;
    endtask : sendFrame
    // clock pulses with enable high, a deliberate host fault
    task automatic strayClocks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            serialClk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            serialClk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
    endtask : strayClocks
endmodule : led_host_model
`default_nettype wire

// file: led_serial_port_tb.sv
// self-checking bench for the led serial load port
`timescale 1ns/1ns
`default_nettype none
module led_serial_port_tb
    import led_port_pkg::*;
;
    logic              ref_clk;
    logic              rst_n;
    logic              cascaded;
    wire logic         serialClk;
    wire logic         serialIn;
    wire logic         loadEnable_n;
    logic              serialOut;
    logic [CFG_W-1:0]  configReg;
    logic [DISP_W-1:0] displayReg;
    logic [4:0]        bankSelect;
    logic [CFG_W-1:0]  expCfg;
    logic [DISP_W-1:0] expDisp;
    logic [47:0]       word;
    int                errorCnt;
    int                samplesChecked;
    int                seed;
    int                lens [9] = '{8, 24, 32, 48, 0, 7, 9, 23, 25};
    always #50 ref_clk = ~ref_clk;
    led_serial_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .serialClk(serialClk),
        .serialIn(serialIn), .loadEnable_n(loadEnable_n), .cascaded(cascaded),
        .serialOut(serialOut), .configReg(configReg), .displayReg(displayReg),
        .bankSelect(bankSelect));
    led_host_model host_u (.ref_clk(ref_clk), .serialOut(serialOut), .serialClk(serialClk),
        .serialIn(serialIn), .loadEnable_n(loadEnable_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic checkReg(input logic [23:0] got, input logic [23:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : checkReg
    // one passed-through bit as the downstream device would capture it
    task automatic checkBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : checkBit
    task automatic checkBoth();
        checkReg({16'h0000, configReg}, {16'h0000, expCfg});
        checkReg(displayReg, expDisp);
    endtask : checkBoth
    // scan model: one lit bank stepping once per slot, all dark with enable bit clear;
    // a lit display showing no single bank expects an impossible mask so it always fails
    task automatic checkBank();
        logic [4:0] seen;
        logic [4:0] expBank;
        seen = bankSelect;
        expBank = expCfg[CFG_ENABLE_BIT] ? 5'h1f : 5'h00;
        for (int b = 0; b < BANK_COUNT; b++) begin
            if (expCfg[CFG_ENABLE_BIT] && seen === 5'(1 << b)) begin
                expBank = 5'(1 << ((b + 1) % BANK_COUNT));
            end
        end
        repeat (BANK_CYCLES) @(posedge ref_clk);
        samplesChecked++;
        if (bankSelect !== expBank) begin
            errorCnt++;
            $display("ERROR %0t got %h expected %h", $time, bankSelect, expBank);
        end
    endtask : checkBank
    // model picks the target from length and cascaded; the last bits are the payload
    task automatic frame(input logic [47:0] bits, input int len, input int half, input int w);
        host_u.sendFrame(bits, len, half);
        if (len == (cascaded ? 32 : 8)) expCfg = bits[7:0];
        else if (len == (cascaded ? 48 : 24)) expDisp = bits[23:0];
        for (int r = 24; r < len; r++) checkBit(host_u.echo[r], bits[len + 23 - r]);
        repeat (w) @(posedge ref_clk);
    endtask : frame
    task automatic completeRun();
        if (errorCnt == 0 && samplesChecked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : completeRun
    ////////////////////////////////////////////////////////////////////////////
    // hang guard, about half again the length of the whole sequence
    initial begin
        #9_000_000;
        errorCnt++;
        completeRun();
    end
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        cascaded = 1'b0;
        seed = 50890;
        expCfg = CFG_RESET;
        expDisp = DISP_RESET;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        checkBoth();
        // display before config, slow clock, checked mid-frame
        word = 48'({$random(seed), $random(seed)});
        fork
            frame(word, 24, 12, 2100);
            begin
                repeat (200) @(posedge ref_clk);
                checkReg(displayReg, expDisp);
            end
        join
        word = 48'({$random(seed), $random(seed)});
        word[0] = 1'b1;
        frame(word, 8, 4, 2100);
        checkBoth();
        checkBank();
        host_u.strayClocks(3);
        frame(48'({$random(seed), $random(seed)}), 24, 4, 2100);
        checkBoth();
        // each length in lens, single and chained; wrong ones load nothing
        for (int c = 0; c < 2; c++) begin
            cascaded <= c[0];
            repeat (4) @(posedge ref_clk);
            foreach (lens[i]) begin
                frame(48'({$random(seed), $random(seed)}), lens[i], 4, 2100);
                checkBoth();
            end
        end
        checkBank();
        cascaded <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // three frames back to back: buffer fills, port holds the third
        frame(48'({$random(seed), $random(seed)}), 24, 4, 0);
        frame(48'({$random(seed), $random(seed)}), 8, 4, 0);
        frame(48'({$random(seed), $random(seed)}), 24, 4, 6100);
        checkBoth();
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        expCfg = CFG_RESET;
        expDisp = DISP_RESET;
        repeat (8) @(posedge ref_clk);
        checkBoth();
        checkBank();
        completeRun();
    end
endmodule : led_serial_port_tb
`default_nettype wire
